//--- core/blink_timer_pkg.sv
/*
  package for the sink blink off-timer: register offsets, field positions,
  reset values, interval tables and register carriers.
  assumes a 10 MHz mclk; all blink intervals are multiples of 0.2 s.
*/
package blink_timer_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFF_TIMES_ADDR  = 8'h12;
  localparam logic [7:0] FADE_RATES_ADDR = 8'h13;
  localparam logic [7:0] OFF_TIMES_RST   = 8'h00;
  localparam logic [7:0] FADE_RATES_RST  = 8'h00;

  // field positions (lsb) inside the off-time and fade-rate registers
  localparam int CH4_OFF_LSB = 6;
  localparam int CH3_OFF_LSB = 4;
  localparam int CH2_OFF_LSB = 2;
  localparam int CH1_OFF_LSB = 0;
  localparam int FADE_OUT_LSB = 4;
  localparam int FADE_IN_LSB  = 0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 200_000_000;  // 0.2 s base unit
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 25;

  // on intervals 0.2/0.6/0.8/1.2 s and off intervals 0.6/1.2/1.8 s in ticks
  localparam int ON_TICKS_00  = 1;
  localparam int ON_TICKS_01  = 3;
  localparam int ON_TICKS_10  = 4;
  localparam int ON_TICKS_11  = 6;
  localparam int OFF_TICKS_01 = 3;
  localparam int OFF_TICKS_10 = 6;
  localparam int OFF_TICKS_11 = 9;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [1:0] ch4_off_time;
    logic [1:0] ch3_off_time;
    logic [1:0] ch2_off_time;
    logic [1:0] ch1_off_time;
  } off_times_t;

  typedef struct packed {
    logic [3:0] fade_out_rate;
    logic [3:0] fade_in_rate;
  } fade_rates_t;

  typedef enum logic [3:0] {
    ST_DARK_IDLE = 4'h1,
    ST_STEADY    = 4'h2,
    ST_LIT       = 4'h4,
    ST_BLINK_OFF = 4'h8
  } chan_state_t;

  function automatic int on_ticks(input logic [1:0] code);
    case (code)
      2'h0:    on_ticks = ON_TICKS_00;
      2'h1:    on_ticks = ON_TICKS_01;
      2'h2:    on_ticks = ON_TICKS_10;
      default: on_ticks = ON_TICKS_11;
    endcase
  endfunction

  function automatic int off_ticks(input logic [1:0] code);
    case (code)
      2'h1:    off_ticks = OFF_TICKS_01;
      2'h2:    off_ticks = OFF_TICKS_10;
      default: off_ticks = OFF_TICKS_11;
    endcase
  endfunction

endpackage

//--- core/sink_blink_off_timer.sv
/*
  blink timing for independent current sinks 1 to 4, plus the fade-rate
  register. registers are written through the internal side of the serial
  host interface (address, data, write strobe) and read back combinationally.
  assumes shared_on_time and chan_sink_enable come from neighbouring registers.
*/
// Functional notes
// - code 00 and enabled: sink steadily on
// - nonzero code: on interval, then off interval
// - off codes 01/10/11 give 0.6/1.2/1.8 s
// - ch4 field bits 7:6, ch3 5:4
// - ch2 field bits 3:2, ch1 1:0
// - sinks enabled together start sequences together
// - fade-rate register lives at address 0x13
// - on codes give 0.2/0.6/0.8/1.2 s
// - each sink has its own enable bit
// - fade-out bits 7:4, fade-in bits 3:0
`timescale 1ns/100ps
module sink_blink_off_timer #(
  parameter int TICK_CYCLES = blink_timer_pkg::TICK_CYCLES,
  parameter int N_CH        = 4
) (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         srst,
  // register access from the host interface
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  output logic      [7:0]                   reg_rdata,
  // neighbouring settings
  input  wire logic [1:0]                   shared_on_time,
  input  wire logic [N_CH-1:0]              chan_sink_enable,
  // sink drive and fade settings
  output logic      [N_CH-1:0]              sink_on,
  output blink_timer_pkg::fade_rates_t      fade_rates
);

  // ****************************************
  // registers
  // ****************************************
  blink_timer_pkg::off_times_t  off_times_ff;
  blink_timer_pkg::fade_rates_t fade_rates_ff;
  logic [1:0]                   chan_off_time [N_CH];

  always_ff @(posedge mclk)
  begin
    if (srst)
      off_times_ff <= blink_timer_pkg::OFF_TIMES_RST;
    else if (reg_wr && reg_addr == blink_timer_pkg::OFF_TIMES_ADDR)
      off_times_ff <= reg_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      fade_rates_ff <= blink_timer_pkg::FADE_RATES_RST;
    else if (reg_wr && reg_addr == blink_timer_pkg::FADE_RATES_ADDR)
      fade_rates_ff <= reg_wdata;
  end

  always_comb
  begin
    if (reg_addr == blink_timer_pkg::OFF_TIMES_ADDR)
      reg_rdata = off_times_ff;
    else if (reg_addr == blink_timer_pkg::FADE_RATES_ADDR)
      reg_rdata = fade_rates_ff;
    else
      reg_rdata = 8'h00;
  end

  assign fade_rates = fade_rates_ff;

  assign chan_off_time[0] = off_times_ff.ch1_off_time;
  assign chan_off_time[1] = off_times_ff.ch2_off_time;
  assign chan_off_time[2] = off_times_ff.ch3_off_time;
  assign chan_off_time[3] = off_times_ff.ch4_off_time;

  // ****************************************
  // per-channel blink sequencers
  // ****************************************
  blink_timer_pkg::chan_state_t    state_ff [N_CH];
  logic [blink_timer_pkg::CNT_W-1:0] cnt_ff [N_CH];

  function automatic logic [blink_timer_pkg::CNT_W-1:0] phase_load(input int ticks);
    phase_load = blink_timer_pkg::CNT_W'(ticks * TICK_CYCLES - 1);
  endfunction

  // each channel counts its own phase from its enable edge, so sinks
  // enabled in the same write with the same off code stay in lockstep
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < N_CH; i++)
    begin
      if (srst)
      begin
        state_ff[i] <= blink_timer_pkg::ST_DARK_IDLE;
        cnt_ff[i]   <= '0;
      end
      else if (!chan_sink_enable[i])
      begin
        state_ff[i] <= blink_timer_pkg::ST_DARK_IDLE;
        cnt_ff[i]   <= '0;
      end
      else if (chan_off_time[i] == 2'h0)
      begin
        state_ff[i] <= blink_timer_pkg::ST_STEADY;
        cnt_ff[i]   <= '0;
      end
      else
      begin
        case (state_ff[i])
          blink_timer_pkg::ST_LIT:
          begin
            if (cnt_ff[i] == '0)
            begin
              state_ff[i] <= blink_timer_pkg::ST_BLINK_OFF;
              cnt_ff[i]   <= phase_load(blink_timer_pkg::off_ticks(chan_off_time[i]));
            end
            else
              cnt_ff[i] <= cnt_ff[i] - 1'b1;
          end
          blink_timer_pkg::ST_BLINK_OFF:
          begin
            if (cnt_ff[i] == '0)
            begin
              state_ff[i] <= blink_timer_pkg::ST_LIT;
              cnt_ff[i]   <= phase_load(blink_timer_pkg::on_ticks(shared_on_time));
            end
            else
              cnt_ff[i] <= cnt_ff[i] - 1'b1;
          end
          default:
          begin
            // sequence starts lit, in the cycle after enable or a change from code 00
            state_ff[i] <= blink_timer_pkg::ST_LIT;
            cnt_ff[i]   <= phase_load(blink_timer_pkg::on_ticks(shared_on_time));
          end
        endcase
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < N_CH; i++)
      sink_on[i] = (state_ff[i] == blink_timer_pkg::ST_STEADY) ||
                   (state_ff[i] == blink_timer_pkg::ST_LIT);
  end

  // ****************************************
  // assertions
  // ****************************************
  a_field_ch4: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == blink_timer_pkg::OFF_TIMES_ADDR
    |=> off_times_ff.ch4_off_time == $past(reg_wdata[7:6]))
    else $error("ch4 off-time field not taken from bits 7:6");

  a_field_ch3: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == blink_timer_pkg::OFF_TIMES_ADDR
    |=> chan_off_time[2] == $past(reg_wdata[5:4]))
    else $error("ch3 off-time field not taken from bits 5:4");

  a_field_ch2: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == blink_timer_pkg::OFF_TIMES_ADDR
    |=> chan_off_time[1] == $past(reg_wdata[3:2]))
    else $error("ch2 off-time field not taken from bits 3:2");

  a_field_ch1: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == blink_timer_pkg::OFF_TIMES_ADDR
    |=> chan_off_time[0] == $past(reg_wdata[1:0]))
    else $error("ch1 off-time field not taken from bits 1:0");

  a_fade_reg: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == blink_timer_pkg::FADE_RATES_ADDR
    |=> reg_addr != blink_timer_pkg::FADE_RATES_ADDR || reg_rdata == $past(reg_wdata))
    else $error("fade-rate register does not read back");

  a_fade_fields: assert property (@(posedge mclk) disable iff (srst)
    reg_wr && reg_addr == blink_timer_pkg::FADE_RATES_ADDR
    |=> fade_rates.fade_out_rate == $past(reg_wdata[7:4])
        && fade_rates.fade_in_rate == $past(reg_wdata[3:0]))
    else $error("fade fields misplaced");

  generate
    for (genvar g = 0; g < N_CH; g++)
    begin : g_chk
      a_steady_on: assert property (@(posedge mclk) disable iff (srst)
        chan_sink_enable[g] && chan_off_time[g] == 2'h0 |=> sink_on[g])
        else $error("steady sink not lit");

      a_disable_dark: assert property (@(posedge mclk) disable iff (srst)
        !chan_sink_enable[g] |=> !sink_on[g])
        else $error("disabled sink still lit");

      a_dark_length: assert property (@(posedge mclk) disable iff (srst)
        state_ff[g] == blink_timer_pkg::ST_LIT && cnt_ff[g] == '0
        && chan_sink_enable[g] && chan_off_time[g] != 2'h0
        |=> !sink_on[g] && cnt_ff[g] ==
            phase_load(blink_timer_pkg::off_ticks($past(chan_off_time[g]))))
        else $error("off interval wrong");

      a_lit_length: assert property (@(posedge mclk) disable iff (srst)
        state_ff[g] == blink_timer_pkg::ST_BLINK_OFF && cnt_ff[g] == '0
        && chan_sink_enable[g] && chan_off_time[g] != 2'h0
        |=> sink_on[g] && cnt_ff[g] ==
            phase_load(blink_timer_pkg::on_ticks($past(shared_on_time))))
        else $error("on interval wrong");

      a_off_hold: assert property (@(posedge mclk) disable iff (srst)
        state_ff[g] == blink_timer_pkg::ST_BLINK_OFF && cnt_ff[g] != '0
        && chan_sink_enable[g] && chan_off_time[g] != 2'h0
        |=> !sink_on[g] && cnt_ff[g] == $past(cnt_ff[g]) - 1'h1)
        else $error("off interval cut short");

      a_lit_hold: assert property (@(posedge mclk) disable iff (srst)
        state_ff[g] == blink_timer_pkg::ST_LIT && cnt_ff[g] != '0
        && chan_sink_enable[g] && chan_off_time[g] != 2'h0
        |=> sink_on[g] && cnt_ff[g] == $past(cnt_ff[g]) - 1'h1)
        else $error("on interval cut short");
    end
  endgenerate

  a_sync_start: assert property (@(posedge mclk) disable iff (srst)
    $rose(chan_sink_enable[0]) && $rose(chan_sink_enable[1])
    && chan_off_time[0] != 2'h0 && chan_off_time[1] != 2'h0
    |=> sink_on[0] && sink_on[1] && cnt_ff[0] == cnt_ff[1])
    else $error("sinks enabled together started apart");

  a_sync_upper: assert property (@(posedge mclk) disable iff (srst)
    $rose(chan_sink_enable[2]) && $rose(chan_sink_enable[3])
    && chan_off_time[2] != 2'h0 && chan_off_time[3] != 2'h0
    |=> sink_on[2] && sink_on[3] && cnt_ff[2] == cnt_ff[3])
    else $error("upper sinks enabled together started apart");

endmodule // sink_blink_off_timer

//--- bench/tb_sink_blink_off_timer.sv
/*
  self-checking bench for sink_blink_off_timer: a cycle model of the blink
  sequencer and of both registers is compared with the design every cycle.
  assumes blink_timer_pkg is compiled first; the tick is shortened to TK.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module tb_sink_blink_off_timer;
  localparam int         TK    = 4;
  localparam logic [7:0] A_OFF = blink_timer_pkg::OFF_TIMES_ADDR;
  localparam logic [7:0] A_FD  = blink_timer_pkg::FADE_RATES_ADDR;
  logic                         mclk;
  logic                         srst;
  logic                         reg_wr;
  logic [7:0]                   reg_addr;
  logic [7:0]                   reg_wdata;
  logic [7:0]                   reg_rdata;
  logic [1:0]                   shared_on_time;
  logic [3:0]                   chan_sink_enable;
  logic [3:0]                   sink_on;
  blink_timer_pkg::fade_rates_t fade_rates;
  int                           bad_count;
  int                           cmp_count;
  int                           cyc;
  int                           on_tk[4]  = '{1, 3, 4, 6};
  int                           off_tk[4] = '{0, 3, 6, 9};
  int                           st[4];
  int                           cnt[4];
  logic [7:0]                   m_off;
  logic [7:0]                   m_fade;
  logic [7:0]                   m_rd;
  logic [3:0]                   m_on;

  sink_blink_off_timer #(.TICK_CYCLES(TK), .N_CH(4)) u_sink_blink_off_timer (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .shared_on_time(shared_on_time),
    .chan_sink_enable(chan_sink_enable), .sink_on(sink_on), .fade_rates(fade_rates));

  // ****************************************
  // clock, watchdog and cycle model
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
    for (int i = 0; i < 4; i++)
    begin
      int c;
      c = m_off[2*i +: 2];
      if (srst || !chan_sink_enable[i])
        st[i] = 0;
      else if (c == 0)
        st[i] = 1;
      else if (st[i] < 2 || (st[i] == 3 && cnt[i] <= 1))
      begin
        st[i] = 2;
        cnt[i] = on_tk[shared_on_time] * TK;
      end
      else if (cnt[i] > 1)
        cnt[i]--;
      else
      begin
        st[i] = 3;
        cnt[i] = off_tk[c] * TK;
      end
      m_on[i] = (st[i] == 1 || st[i] == 2);
    end
    if (srst)
    begin
      m_off = blink_timer_pkg::OFF_TIMES_RST;
      m_fade = blink_timer_pkg::FADE_RATES_RST;
    end
    else if (reg_wr && reg_addr == A_OFF)
      m_off = reg_wdata;
    else if (reg_wr && reg_addr == A_FD)
      m_fade = reg_wdata;
  end

  always @(negedge mclk)
    if (cyc > 1)
    begin
      m_rd = (reg_addr == A_OFF) ? m_off : (reg_addr == A_FD) ? m_fade : 8'h00;
      `CHK("sink_on", m_on, sink_on)
      `CHK("reg_rdata", m_rd, reg_rdata)
      `CHK("fade_rates", m_fade, fade_rates)
    end

  // ****************************************
  // tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    shared_on_time = 2'h0;
    chan_sink_enable = 4'h0;
    void'($urandom(78113));
    repeat (12) @(posedge mclk);
    #1;
    srst = 1'b0;
    // unmapped places ignore writes and read as zero
    wr(8'h11, 8'hA5);
    wr(8'h14, 8'h5A);
    wr(A_FD, 8'($urandom));
    // every code in every field, every on code, all sinks enabled at once
    for (int k = 0; k < 4; k++)
    begin
      wr(A_OFF, {2'(k + 3), 2'(k + 2), 2'(k + 1), 2'(k)});
      shared_on_time = 2'(k);
      chan_sink_enable = 4'hF;
      tick(90);
      wr(A_OFF, 8'hFF);
      tick(70);
      chan_sink_enable = 4'h0;
      tick(3);
    end
    for (int r = 0; r < 10; r++)
    begin
      wr(A_OFF, 8'($urandom));
      reg_addr = A_OFF + 8'($urandom_range(1));
      shared_on_time = 2'($urandom);
      chan_sink_enable = 4'($urandom);
      tick(40 + $urandom_range(120));
      shared_on_time = 2'($urandom);
      tick($urandom_range(60));
      chan_sink_enable = 4'h0;
      tick(2);
    end
    // reset in mid-run clears registers and sinks
    chan_sink_enable = 4'hF;
    tick(10);
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    tick(20);
    report_and_stop();
  end
endmodule // tb_sink_blink_off_timer
